// >>> ctpg_defs.svh
// Purpose: Constants for the camera test pattern generator
// Assumes: Register port with byte offsets on an 8-bit address
// Notes: Offsets, field positions, reset values, address width and FIFO depth only
`ifndef CTPG_DEFS_SVH
`define CTPG_DEFS_SVH

`define CTPG_ADDR_W 8
`define CTPG_OFS_CTRL 8'h00
`define CTPG_OFS_WIDTH 8'h04
`define CTPG_OFS_HEIGHT 8'h08
`define CTPG_OFS_STATUS 8'h0C
`define CTPG_OFS_FRAMES 8'h10

`define CTPG_CTRL_SEL_LSB 0
`define CTPG_CTRL_SEL_MSB 2
`define CTPG_CTRL_ACQ_BIT 3
`define CTPG_CTRL_FEXT_BIT 4
`define CTPG_CTRL_LEXT_BIT 5
`define CTPG_STAT_BUSY_BIT 3

`define CTPG_RST_SEL 3'h0
`define CTPG_RST_WIDTH 12'h800
`define CTPG_RST_HEIGHT 12'h001
`define CTPG_FIFO_DEPTH 16

`endif

// >>> ctpg_mem_model.sv
// Purpose: Frame memory sink model for the test pattern generator
// Assumes: Same clock as the generator; words taken on valid and ready
// Notes: hold_i refuses all words; slow_i drops ready two cycles in eight
`timescale 1ns/1ps

module ctpg_mem_model
   import ctpg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire ctpg_pix_t pix_i,
   input wire logic valid_i,
   output logic ready_o,
   input wire logic hold_i,
   input wire logic slow_i
);
   ctpg_pix_t q[$];
   logic [2:0] phase;

   // Irregular stalls so the FIFO output sees backpressure mid-line
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         phase <= 3'h0;
         ready_o <= 1'b0;
      end else begin
         phase <= phase + 3'h1;
         ready_o <= !hold_i && (!slow_i || (phase != 3'h2 && phase != 3'h5));
      end
   end

   always @(posedge sys_clk_i) begin
      if (resetn_i && valid_i && ready_o) begin
         q.push_back(pix_i);
      end
   end
endmodule // ctpg_mem_model

// >>> ctpg_pkg.sv
// Purpose: Types for the camera test pattern generator
// Assumes: Pixels are at most 12 bits wide
// Notes: Constants live in ctpg_defs.svh
package ctpg_pkg;

   typedef enum logic [2:0] {
      CTPG_OFF = 3'b000,
      CTPG_P1 = 3'b001,
      CTPG_P2 = 3'b010,
      CTPG_P3 = 3'b011,
      CTPG_P4 = 3'b100,
      CTPG_P5 = 3'b101
   } ctpg_sel_t;

   typedef enum logic [1:0] {
      CTPG_IDLE = 2'b00,
      CTPG_LINE_WAIT = 2'b01,
      CTPG_RUN = 2'b10
   } ctpg_state_t;

   typedef struct packed {
      logic [11:0] data;
      logic sof;
      logic sol;
      logic eol;
      logic eof;
      logic bypass;
   } ctpg_pix_t;

endpackage

// >>> ctpg_top.sv
// Purpose: Test pattern generator feeding frame memory in place of sensor data
// Assumes: Sensor stream and frame memory on sys_clk_i; trigger pins are asynchronous
// Notes: Summary of operation
// Summary of operation
// - Selected pattern makes every line internally; sensor and ADC path unused.
// - Pattern lines go to frame memory like sensor frames, then to transmission.
// - Pattern frame size comes from the normal width and height settings.
// - With external trigger sources, frames and lines wait for those pin edges.
// - Analog gain, black level and exposure never touch pattern pixel values.
// - Patterns one to three bypass all digital processing features.
// - Patterns four and five pass through the enabled digital features.
// - Selection picks one pattern or off, which restores sensor imaging.
// - Pattern one is a fixed 8-bit gradient spanning 0 to 255.
// - Pattern one pixel is column plus row, modulo 256.
// - Pattern two pixel is column plus row plus frame counter, modulo 256.
// - Frame counter increments by one at each new frame start.
// - Moving gradient shifts one pixel right to left every frame.
// - Pattern three is column plus row plus counter, modulo 4096, 12 bits.
// - Pattern four uses the same 8-bit moving gradient as pattern two.
// - Pattern five uses the same 12-bit moving gradient as pattern three.
`timescale 1ns/1ps
`include "ctpg_defs.svh"

module ctpg_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Output register keeps the top-level outputs straight from flops
   assign in_ready_o = (count != DEPTH[AW:0]);
   assign push = in_valid_i && in_ready_o;
   assign pop = (count != '0) && (!out_valid_o || out_ready_i);

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem[rd_ptr];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule // ctpg_fifo

module ctpg_top
   import ctpg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [`CTPG_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic frame_trig_i,
   input wire logic line_trig_i,
   input wire ctpg_pix_t sensor_pix_i,
   input wire logic sensor_valid_i,
   output logic sensor_ready_o,
   output ctpg_pix_t mem_pix_o,
   output logic mem_valid_o,
   input wire logic mem_ready_i,
   output logic busy_o
);
   logic [2:0] ctrl_sel;
   logic acq_en;
   logic frame_ext;
   logic line_ext;
   logic [11:0] width;
   logic [11:0] height;
   ctpg_sel_t active_sel;
   ctpg_state_t state;
   logic [11:0] col;
   logic [11:0] row;
   logic [11:0] frame_cnt;
   logic sensor_in_frame;
   logic [2:0] ftrig_sync;
   logic [2:0] ltrig_sync;
   logic frame_rise;
   logic line_rise;
   logic frame_start;
   logic line_go;
   logic fifo_ready;
   logic fifo_valid;
   ctpg_pix_t fifo_in;
   ctpg_pix_t gen_pix;
   logic gen_push;
   logic sensor_take;
   logic [4:0] fifo_level;

   function automatic logic [11:0] grad(input ctpg_sel_t sel, input logic [11:0] c,
                                        input logic [11:0] r, input logic [11:0] n);
      logic [11:0] sum;
      sum = c + r + n;
      unique case (sel)
         CTPG_P1: grad = {4'h0, c[7:0] + r[7:0]};
         CTPG_P2, CTPG_P4: grad = {4'h0, sum[7:0]};
         CTPG_P3, CTPG_P5: grad = sum;
         default: grad = 12'h000;
      endcase
   endfunction

   // Register writes
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ctrl_sel <= `CTPG_RST_SEL;
         acq_en <= 1'b0;
         frame_ext <= 1'b0;
         line_ext <= 1'b0;
         width <= `CTPG_RST_WIDTH;
         height <= `CTPG_RST_HEIGHT;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            `CTPG_OFS_CTRL: begin
               ctrl_sel <= reg_wdata_i[`CTPG_CTRL_SEL_MSB:`CTPG_CTRL_SEL_LSB];
               acq_en <= reg_wdata_i[`CTPG_CTRL_ACQ_BIT];
               frame_ext <= reg_wdata_i[`CTPG_CTRL_FEXT_BIT];
               line_ext <= reg_wdata_i[`CTPG_CTRL_LEXT_BIT];
            end
            `CTPG_OFS_WIDTH: width <= reg_wdata_i[11:0];
            `CTPG_OFS_HEIGHT: height <= reg_wdata_i[11:0];
            default: ;
         endcase
      end
   end

   // Register reads, data one cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            `CTPG_OFS_CTRL: reg_rdata_o <= {26'h0, line_ext, frame_ext, acq_en, ctrl_sel};
            `CTPG_OFS_WIDTH: reg_rdata_o <= {20'h0, width};
            `CTPG_OFS_HEIGHT: reg_rdata_o <= {20'h0, height};
            `CTPG_OFS_STATUS: reg_rdata_o <= {28'h0, (state != CTPG_IDLE), active_sel};
            `CTPG_OFS_FRAMES: reg_rdata_o <= {20'h0, frame_cnt};
            default: reg_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   // Trigger pins: two flops, then an edge detector on later stages
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ftrig_sync <= 3'h0;
         ltrig_sync <= 3'h0;
      end else begin
         ftrig_sync <= {ftrig_sync[1:0], frame_trig_i};
         ltrig_sync <= {ltrig_sync[1:0], line_trig_i};
      end
   end
   assign frame_rise = ftrig_sync[1] && !ftrig_sync[2];
   assign line_rise = ltrig_sync[1] && !ltrig_sync[2];

   assign frame_start = (state == CTPG_IDLE) && (active_sel != CTPG_OFF) && acq_en &&
                        (!frame_ext || frame_rise);
   assign line_go = !line_ext || line_rise;

   // Sensor frame tracking so selection holds from the cycle after a sensor sof is taken until eof
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         sensor_in_frame <= 1'b0;
      end else if (sensor_take) begin
         if (sensor_pix_i.eof) begin
            sensor_in_frame <= 1'b0;
         end else if (sensor_pix_i.sof) begin
            sensor_in_frame <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         active_sel <= CTPG_OFF;
      end else if (state == CTPG_IDLE && !sensor_in_frame && !frame_start) begin
         unique case (ctrl_sel)
            3'b001: active_sel <= CTPG_P1;
            3'b010: active_sel <= CTPG_P2;
            3'b011: active_sel <= CTPG_P3;
            3'b100: active_sel <= CTPG_P4;
            3'b101: active_sel <= CTPG_P5;
            default: active_sel <= CTPG_OFF;
         endcase
      end
   end

   // Generator sequencing
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state <= CTPG_IDLE;
         col <= 12'h000;
         row <= 12'h000;
      end else begin
         unique case (state)
            CTPG_IDLE: begin
               if (frame_start) begin
                  col <= 12'h000;
                  row <= 12'h000;
                  state <= CTPG_LINE_WAIT;
               end
            end
            CTPG_LINE_WAIT: begin
               if (line_go) begin
                  state <= CTPG_RUN;
               end
            end
            CTPG_RUN: begin
               if (gen_push) begin
                  if (col == width - 12'h001) begin
                     col <= 12'h000;
                     if (row == height - 12'h001) begin
                        state <= CTPG_IDLE;
                     end else begin
                        row <= row + 12'h001;
                        state <= CTPG_LINE_WAIT;
                     end
                  end else begin
                     col <= col + 12'h001;
                  end
               end
            end
            default: state <= CTPG_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         frame_cnt <= 12'h000;
      end else if (frame_start) begin
         frame_cnt <= frame_cnt + 12'h001;
      end
   end

   // Pixels computed from position and frame counter only; analog settings have no path here
   always_comb begin
      gen_pix.data = grad(active_sel, col, row, frame_cnt);
      gen_pix.sof = (col == 12'h000) && (row == 12'h000);
      gen_pix.sol = (col == 12'h000);
      gen_pix.eol = (col == width - 12'h001);
      gen_pix.eof = gen_pix.eol && (row == height - 12'h001);
      gen_pix.bypass = (active_sel == CTPG_P1) || (active_sel == CTPG_P2) ||
                       (active_sel == CTPG_P3);
   end

   assign gen_push = (state == CTPG_RUN) && fifo_ready;
   assign sensor_take = sensor_valid_i && sensor_ready_o;
   assign fifo_valid = gen_push || (sensor_take && active_sel == CTPG_OFF);
   assign fifo_in = (state == CTPG_RUN) ? gen_pix : sensor_pix_i;

   // Registered ready with one word of headroom for the stale cycle
   // Level spans FIFO and output stage, so it never under-reports
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         sensor_ready_o <= 1'b0;
         fifo_level <= 5'h00;
      end else begin
         fifo_level <= fifo_level + {4'h0, fifo_valid && fifo_ready} -
                       {4'h0, mem_valid_o && mem_ready_i};
         sensor_ready_o <= (active_sel == CTPG_OFF) && (state == CTPG_IDLE) &&
                           (fifo_level < 5'(`CTPG_FIFO_DEPTH - 2));
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= frame_start || (state != CTPG_IDLE && !(gen_push && gen_pix.eof));
      end
   end

   ctpg_fifo #(
      .WIDTH($bits(ctpg_pix_t)),
      .DEPTH(`CTPG_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(fifo_valid),
      .in_ready_o(fifo_ready),
      .in_data_i(fifo_in),
      .out_valid_o(mem_valid_o),
      .out_ready_i(mem_ready_i),
      .out_data_o(mem_pix_o)
   );

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_sensor_held_off: assert property (
      active_sel != CTPG_OFF |=> !sensor_ready_o)
      else $error("sensor accepted while a pattern is active");
   a_counter_step: assert property (
      frame_start |=> frame_cnt == $past(frame_cnt) + 12'h001)
      else $error("frame counter did not step by one");
   a_fixed_gradient: assert property (
      gen_push && active_sel == CTPG_P1 |-> fifo_in.data == {4'h0, col[7:0] + row[7:0]})
      else $error("pattern one pixel wrong");
   a_moving_gradient: assert property (
      gen_push && active_sel == CTPG_P2 |->
      fifo_in.data[7:0] == 8'(col + row + frame_cnt) && fifo_in.data[11:8] == 4'h0)
      else $error("pattern two pixel wrong");
   a_wide_gradient: assert property (
      gen_push && active_sel == CTPG_P3 |-> fifo_in.data == 12'(col + row + frame_cnt))
      else $error("pattern three pixel wrong");
   a_bypass_route: assert property (
      gen_push |-> fifo_in.bypass == (active_sel inside {CTPG_P1, CTPG_P2, CTPG_P3}))
      else $error("digital bypass flag wrong");
   a_frame_origin: assert property (
      frame_start |=> col == 12'h000 && row == 12'h000 ##1 state != CTPG_IDLE)
      else $error("frame did not start at origin");
   a_select_frozen: assert property (
      state != CTPG_IDLE |=> $stable(active_sel))
      else $error("selection changed inside a frame");
   a_line_trigger: assert property (
      state == CTPG_LINE_WAIT && line_ext && !line_rise |=> state == CTPG_LINE_WAIT)
      else $error("line started without external trigger");
   a_line_length: assert property (
      gen_push && col == width - 12'h001 |-> fifo_in.eol ##1 col == 12'h000)
      else $error("line length differs from width setting");
   a_feature_narrow: assert property (
      gen_push && active_sel == CTPG_P4 |-> fifo_in.data == {4'h0, 8'(col + row + frame_cnt)})
      else $error("pattern four pixel wrong");
   a_feature_wide: assert property (
      gen_push && active_sel == CTPG_P5 |-> fifo_in.data == 12'(col + row + frame_cnt))
      else $error("pattern five pixel wrong");
endmodule // ctpg_top

// >>> ctpg_top_tb_top.sv
// Purpose: Self-checking bench for the test pattern generator
// Assumes: External frame trigger so every frame start is counted here
// Notes: Junk sensor words are offered while patterns run
`timescale 1ns/1ps
`include "ctpg_defs.svh"

module ctpg_top_tb_top
   import ctpg_pkg::*;
;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic ftrig = 1'b0;
   logic ltrig = 1'b0;
   logic sv = 1'b0;
   logic hold = 1'b0;
   logic slow = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   ctpg_pix_t spix = '0;
   logic [31:0] rdata;
   ctpg_pix_t mpix;
   logic mvalid, mready, sready, busy;
   logic [11:0] cnt = 12'h000;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;

   ctpg_top uut (.sys_clk_i(sys_clk), .resetn_i(resetn), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
      .frame_trig_i(ftrig), .line_trig_i(ltrig), .sensor_pix_i(spix),
      .sensor_valid_i(sv), .sensor_ready_o(sready), .mem_pix_o(mpix),
      .mem_valid_o(mvalid), .mem_ready_i(mready), .busy_o(busy));

   ctpg_mem_model mem (.sys_clk_i(sys_clk), .resetn_i(resetn), .pix_i(mpix),
      .valid_i(mvalid), .ready_o(mready), .hold_i(hold), .slow_i(slow));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop();
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Whole run is well under this; a hang lands in the same report
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cmp_pix(input ctpg_pix_t g, input ctpg_pix_t e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1 cmp_reg(rdata, e);
   endtask

   // Pin edge held three cycles to clear the synchroniser
   task automatic pulse(input logic line);
      @(posedge sys_clk);
      if (line) ltrig <= 1'b1;
      else ftrig <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ltrig <= 1'b0;
      ftrig <= 1'b0;
   endtask

   task automatic get(output ctpg_pix_t g);
      int i;
      i = 0;
      while (mem.q.size() == 0 && i < 3000) begin
         @(posedge sys_clk);
         i++;
      end
      if (mem.q.size() == 0) begin
         fail_count++;
         g = '1;
      end else g = mem.q.pop_front();
   endtask

   function automatic ctpg_pix_t sword(input int k);
      ctpg_pix_t p;
      p = '0;
      p.data = 12'h5A0 + 12'(k);
      p.sof = (k == 0);
      p.sol = (k == 0);
      p.eol = (k == 2);
      p.eof = (k == 2);
      p.bypass = k[0];
      return p;
   endfunction

   task automatic sensor_pass();
      int i;
      ctpg_pix_t g;
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk);
         spix <= sword(k);
         sv <= 1'b1;
         i = 0;
         do begin
            @(negedge sys_clk);
            i++;
         end while (sready !== 1'b1 && i < 200);
         @(posedge sys_clk);
         sv <= 1'b0;
      end
      for (int k = 0; k < 3; k++) begin
         get(g);
         cmp_pix(g, sword(k));
      end
   endtask

   task automatic run_frame(input ctpg_sel_t s, input int w, input int h,
                            input logic lx, input logic stall);
      ctpg_pix_t e;
      ctpg_pix_t g;
      logic [12:0] v;
      cnt = cnt + 12'h001;
      hold <= stall;
      wr(`CTPG_OFS_CTRL, {26'h0, lx, 2'b11, s});
      wr(`CTPG_OFS_WIDTH, 32'(w[11:0]));
      wr(`CTPG_OFS_HEIGHT, 32'(h));
      pulse(1'b0);
      repeat (10) @(posedge sys_clk);
      sv <= 1'b1;
      spix <= '{data: 12'hABC, default: 1'b0};
      #1 cmp_reg({31'h0, sready}, 32'h0);
      if (stall) begin
         repeat (100) @(posedge sys_clk);
         hold <= 1'b0;
         #1 cmp_reg({31'h0, busy}, 32'h1);
      end
      for (int r = 0; r < h; r++) begin
         if (lx) begin
            repeat (40) @(posedge sys_clk);
            #1 cmp_reg(32'(mem.q.size()), 32'h0);
            if (r == 1) begin
               wr(`CTPG_OFS_CTRL, {26'h0, lx, 2'b11, CTPG_P1});
               rd_chk(`CTPG_OFS_STATUS, {28'h0, 1'b1, s});
            end
            pulse(1'b1);
         end
         for (int c = 0; c < w; c++) begin
            v = 13'(c) + 13'(r) + ((s == CTPG_P1) ? 13'h0 : 13'(cnt));
            e = '0;
            e.data = (s == CTPG_P3 || s == CTPG_P5) ? v[11:0] : {4'h0, v[7:0]};
            e.sof = (c == 0 && r == 0);
            e.sol = (c == 0);
            e.eol = (c == w - 1);
            e.eof = e.eol && (r == h - 1);
            e.bypass = (s <= CTPG_P3);
            get(g);
            cmp_pix(g, e);
         end
      end
      sv <= 1'b0;
      repeat (30) @(posedge sys_clk);
      #1 cmp_reg(32'(mem.q.size()), 32'h0);
      rd_chk(`CTPG_OFS_FRAMES, {20'h0, cnt});
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      rd_chk(`CTPG_OFS_CTRL, 32'h0);
      rd_chk(`CTPG_OFS_WIDTH, 32'h800);
      rd_chk(`CTPG_OFS_HEIGHT, 32'h1);
      rd_chk(`CTPG_OFS_STATUS, 32'h0);
      rd_chk(`CTPG_OFS_FRAMES, 32'h0);
      wr(8'h14, 32'hFFFFFFFF);
      rd_chk(8'h14, 32'h0);
      sensor_pass();
      run_frame(CTPG_P1, 40, 1, 1'b0, 1'b1);
      run_frame(CTPG_P2, 300, 2, 1'b0, 1'b0);
      run_frame(CTPG_P3, 4096, 1, 1'b0, 1'b0);
      run_frame(CTPG_P4, 5, 3, 1'b0, 1'b0);
      run_frame(CTPG_P5, 4, 3, 1'b1, 1'b0);
      run_frame(CTPG_P1, 3, 2, 1'b0, 1'b0);
      wr(`CTPG_OFS_CTRL, 32'h6);
      rd_chk(`CTPG_OFS_CTRL, 32'h6);
      rd_chk(`CTPG_OFS_STATUS, 32'h0);
      sensor_pass();
      report_and_stop();
   end
endmodule // ctpg_top_tb_top
